// File: verilog/fdcx_pkg.sv
// How it works
// - the four disk commands run command bytes in, then execution, then result bytes out; version and unknown opcodes go straight to one result byte.
// - the skip flag in the first byte makes verify pass over sectors with a deleted mark.
// - the two drive select bits of the second byte pick the drive the command works on.
// - read track streams the track from the index pulse up to the final sector to the host.
// - read track ends with seven result bytes: three status bytes then C, H, R and N.
// - read id takes opcode and select byte and captures the first good id field it sees.
// - read id returns three status bytes and the captured C, H, R and N.
// - verify checks the addressed sectors with no data moved and returns seven bytes.
// - verify bit 7 of byte two is count enable; the last byte is then a sector count.
// - write data takes the read parameter list, moves host data to the drive, returns seven.
package fdcx_pkg;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 8;
   // opcodes, low five bits of the first byte
   localparam logic [4:0] OPC_READ_TRACK = 5'h02;
   localparam logic [4:0] OPC_READ_ID = 5'h0a;
   localparam logic [4:0] OPC_VERIFY = 5'h16;
   localparam logic [4:0] OPC_WRITE = 5'h05;
   localparam logic [4:0] OPC_VERSION = 5'h10;
   // field positions
   localparam int BIT_MULTI = 7;
   localparam int BIT_DENSITY = 6;
   localparam int BIT_SKIP = 5;
   localparam int BIT_COUNT_EN = 7;
   localparam int BIT_HEAD = 2;
   // byte counts
   localparam logic [3:0] LEN_FULL = 4'h9;
   localparam logic [3:0] LEN_SEL = 4'h2;
   localparam logic [3:0] IDX_SEL = 4'h1;
   localparam logic [3:0] IDX_CYL = 4'h2;
   localparam logic [3:0] IDX_HEAD = 4'h3;
   localparam logic [3:0] IDX_REC = 4'h4;
   localparam logic [3:0] IDX_SIZE = 4'h5;
   localparam logic [3:0] IDX_EOT = 4'h6;
   localparam logic [3:0] IDX_GAP = 4'h7;
   localparam logic [2:0] RES_FULL = 3'h7;
   localparam logic [2:0] RES_ONE = 3'h1;
   // status codes
   localparam logic [1:0] INT_NORMAL = 2'h0;
   localparam logic [1:0] INT_ABNORMAL = 2'h1;
   localparam logic [7:0] ST0_INVALID = 8'h80;
   localparam logic [7:0] ST1_MISSING_AM = 8'h01;
   localparam logic [7:0] ST2_CTRL_MARK = 8'h40;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [1:0] MISS_INDEX = 2'h2;
   localparam logic [7:0] ONE_BYTE = 8'h01;

   typedef struct packed {
      logic [7:0] cyl;
      logic [7:0] head;
      logic [7:0] rec;
      logic [7:0] size;
   } fdcx_id_t;

   typedef struct packed {
      logic [4:0] opcode;
      logic multiTrack;
      logic dblDensity;
      logic skipDeleted;
      logic countEnable;
      logic headSelect;
      logic [1:0] driveSel;
      fdcx_id_t id;
      logic [7:0] finalSector;
      logic [7:0] gapLength;
      logic [7:0] lenOrCount;
   } fdcx_cmd_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_PARAM = 4'b0010,
      ST_EXEC = 4'b0100,
      ST_RESULT = 4'b1000
   } fdcx_state_t;
endpackage

// File: verilog/fdcx_cmd.sv
`timescale 1ns/1ns
// ****************
// data buffer
// ****************
module fdcx_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic flush,
   // fill side
   input wire logic inValid,
   input wire logic [W-1:0] inData,
   output logic inReady,
   // drain side
   output logic outValid,
   output logic [W-1:0] outData,
   input wire logic outReady
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   assign inReady = (count_q != (AW+1)'(D));
   assign outValid = (count_q != '0);
   assign outData = mem[rdPtr_q];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else if (flush) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wrPtr_q <= (wrPtr_q == AW'(D-1)) ? '0 : wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= (rdPtr_q == AW'(D-1)) ? '0 : rdPtr_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ****************
// command interpreter
// ****************
module fdcx_cmd #(
   parameter logic [7:0] VERSION_CODE = 8'h5a, // arbitrary value
   parameter int DEPTH = fdcx_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // host command bytes
   input wire logic cmdValid,
   input wire logic [7:0] cmdByte,
   output logic cmdReady,
   // host result bytes
   output logic resValid,
   output logic [7:0] resByte,
   input wire logic resReady,
   // host data
   input wire logic hostWrValid,
   input wire logic [7:0] hostWrByte,
   output logic hostWrReady,
   output logic hostRdValid,
   output logic [7:0] hostRdByte,
   input wire logic hostRdReady,
   // drive side
   input wire logic drvIndex,
   input wire logic drvIdValid,
   input wire fdcx_pkg::fdcx_id_t drvId,
   input wire logic drvIdCrcOk,
   input wire logic drvIdDeleted,
   input wire logic drvSecEnd,
   input wire logic drvRdValid,
   input wire logic [7:0] drvRdByte,
   output logic drvRdReady,
   output logic drvWrValid,
   output logic [7:0] drvWrByte,
   input wire logic drvWrReady,
   // drive controls
   output logic [1:0] driveSel,
   output logic headSel,
   output logic dblDensity,
   output logic readGate,
   output logic writeGate,
   output logic busy
);
   import fdcx_pkg::*;

   fdcx_state_t state_q;
   fdcx_cmd_t cmd_q;
   fdcx_id_t curId_q;
   logic [3:0] byteCnt_q;
   logic [3:0] needCnt_q;
   logic [2:0] resIdx_q;
   logic [2:0] resCnt_q;
   logic [7:0] st0_q;
   logic [7:0] st1_q;
   logic [7:0] st2_q;
   logic [7:0] secCnt_q;
   logic [1:0] idxSeen_q;
   logic started_q;
   logic matched_q;
   logic draining_q;
   logic resValid_q;
   logic [7:0] resByte_q;
   logic [1:0] driveSel_q;
   logic headSel_q;
   logic dblDensity_q;
   logic readGate_q;
   logic writeGate_q;
   logic busy_q;

   logic isTrack;
   logic isWrite;
   logic isSector;
   logic streaming;
   logic finish;
   logic abnormal;
   logic lastSector;
   logic idHit;
   logic fifoInValid;
   logic [7:0] fifoInByte;
   logic fifoInReady;
   logic fifoOutValid;
   logic [7:0] fifoOutByte;
   logic fifoOutReady;
   logic inExec;

   // ****************
   // execution conditions
   // ****************
   assign inExec = (state_q == ST_EXEC);
   assign isTrack = (cmd_q.opcode == OPC_READ_TRACK);
   assign isWrite = (cmd_q.opcode == OPC_WRITE);
   assign isSector = isWrite || (cmd_q.opcode == OPC_VERIFY);
   assign streaming = inExec && isTrack && started_q && !draining_q;
   assign idHit = drvIdValid && drvIdCrcOk && (drvId.rec == curId_q.rec);
   assign lastSector = (cmd_q.countEnable && !isWrite)
                       ? (secCnt_q + ONE_BYTE == cmd_q.lenOrCount)
                       : (curId_q.rec == cmd_q.finalSector);
   assign abnormal = (idxSeen_q == MISS_INDEX);

   always_comb begin
      finish = 1'b0;
      if (inExec) begin
         case (cmd_q.opcode)
            OPC_READ_ID: finish = (drvIdValid && drvIdCrcOk) || abnormal;
            OPC_READ_TRACK: finish = draining_q && !fifoOutValid;
            default: finish = (matched_q && drvSecEnd && lastSector) || abnormal;
         endcase
      end
   end

   // ****************
   // data path through buffer
   // ****************
   assign fifoInValid = isTrack ? (drvRdValid && streaming) : (hostWrValid && inExec && isWrite);
   assign fifoInByte = isTrack ? drvRdByte : hostWrByte;
   assign fifoOutReady = isTrack ? hostRdReady : (drvWrReady && writeGate_q);

   fdcx_fifo #(.W(BYTE_W), .D(DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .flush(state_q == ST_IDLE),
      .inValid(fifoInValid),
      .inData(fifoInByte),
      .inReady(fifoInReady),
      .outValid(fifoOutValid),
      .outData(fifoOutByte),
      .outReady(fifoOutReady)
   );

   assign drvRdReady = fifoInReady && streaming;
   assign hostWrReady = fifoInReady && inExec && isWrite;
   assign hostRdValid = fifoOutValid && isTrack;
   assign hostRdByte = fifoOutByte;
   assign drvWrValid = fifoOutValid && writeGate_q;
   assign drvWrByte = fifoOutByte;

   // ****************
   // phase sequencer
   // ****************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         byteCnt_q <= '0;
         needCnt_q <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (cmdValid) begin
                  byteCnt_q <= IDX_SEL;
                  case (cmdByte[4:0])
                     OPC_READ_ID: needCnt_q <= LEN_SEL;
                     default: needCnt_q <= LEN_FULL;
                  endcase
                  case (cmdByte[4:0])
                     OPC_READ_TRACK, OPC_READ_ID, OPC_VERIFY, OPC_WRITE: state_q <= ST_PARAM;
                     default: state_q <= ST_RESULT;
                  endcase
               end
            end
            ST_PARAM: begin
               if (cmdValid) begin
                  byteCnt_q <= byteCnt_q + 1'b1;
                  if (byteCnt_q + 1'b1 == needCnt_q) begin
                     state_q <= ST_EXEC;
                  end
               end
            end
            ST_EXEC: begin
               if (finish) begin
                  state_q <= ST_RESULT;
               end
            end
            ST_RESULT: begin
               if (resValid_q && resReady && resIdx_q + 1'b1 == resCnt_q) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ****************
   // parameter capture
   // ****************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmd_q <= '0;
      end else if (cmdValid && state_q == ST_IDLE) begin
         cmd_q <= '0;
         cmd_q.opcode <= cmdByte[4:0];
         cmd_q.multiTrack <= cmdByte[BIT_MULTI];
         cmd_q.dblDensity <= cmdByte[BIT_DENSITY];
         cmd_q.skipDeleted <= cmdByte[BIT_SKIP];
      end else if (cmdValid && state_q == ST_PARAM) begin
         case (byteCnt_q)
            IDX_SEL: begin
               cmd_q.countEnable <= cmdByte[BIT_COUNT_EN];
               cmd_q.headSelect <= cmdByte[BIT_HEAD];
               cmd_q.driveSel <= cmdByte[1:0];
            end
            IDX_CYL: cmd_q.id.cyl <= cmdByte;
            IDX_HEAD: cmd_q.id.head <= cmdByte;
            IDX_REC: cmd_q.id.rec <= cmdByte;
            IDX_SIZE: cmd_q.id.size <= cmdByte;
            IDX_EOT: cmd_q.finalSector <= cmdByte;
            IDX_GAP: cmd_q.gapLength <= cmdByte;
            default: cmd_q.lenOrCount <= cmdByte;
         endcase
      end
   end

   // ****************
   // sector tracking
   // ****************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         curId_q <= '0;
         secCnt_q <= '0;
         idxSeen_q <= '0;
         started_q <= 1'b0;
         matched_q <= 1'b0;
         draining_q <= 1'b0;
      end else if (!inExec) begin
         if (state_q != ST_RESULT) begin
            curId_q <= cmd_q.id; // keep the last id for the result bytes
         end
         secCnt_q <= '0;
         idxSeen_q <= '0;
         started_q <= 1'b0;
         matched_q <= 1'b0;
         draining_q <= 1'b0;
      end else begin
         if (drvIndex && !started_q) begin
            started_q <= 1'b1;
         end
         if (drvIndex && !matched_q && !isTrack && !abnormal) begin
            idxSeen_q <= idxSeen_q + 1'b1;
         end
         if (isTrack && started_q && drvIdValid && !draining_q) begin
            curId_q <= drvId;
         end
         if (isTrack && started_q && drvSecEnd && curId_q.rec == cmd_q.finalSector) begin
            draining_q <= 1'b1;
         end
         if (!isTrack && !isSector && drvIdValid && drvIdCrcOk) begin
            curId_q <= drvId;
         end
         if (isSector && idHit && !matched_q) begin
            curId_q <= drvId;
            matched_q <= !(drvIdDeleted && cmd_q.skipDeleted && !isWrite);
            idxSeen_q <= '0;
         end
         if (isSector && matched_q && drvSecEnd && !lastSector) begin
            matched_q <= 1'b0;
            secCnt_q <= secCnt_q + ONE_BYTE;
            curId_q.rec <= curId_q.rec + ONE_BYTE;
         end
         if (isSector && idHit && !matched_q && drvIdDeleted && cmd_q.skipDeleted && !isWrite) begin
            curId_q.rec <= curId_q.rec + ONE_BYTE;
         end
      end
   end

   // ****************
   // status bytes
   // ****************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st0_q <= '0;
         st1_q <= '0;
         st2_q <= '0;
         resCnt_q <= '0;
      end else if (state_q == ST_IDLE && cmdValid) begin
         st1_q <= '0;
         st2_q <= '0;
         resCnt_q <= RES_ONE;
         st0_q <= (cmdByte[4:0] == OPC_VERSION) ? VERSION_CODE : ST0_INVALID;
      end else if (finish) begin
         resCnt_q <= RES_FULL;
         st0_q <= {abnormal ? INT_ABNORMAL : INT_NORMAL, 3'h0, cmd_q.headSelect, cmd_q.driveSel};
         st1_q <= abnormal ? ST1_MISSING_AM : ZERO_BYTE;
      end else if (inExec && idHit && drvIdDeleted && cmd_q.skipDeleted && isSector) begin
         st2_q <= ST2_CTRL_MARK;
      end
   end

   // ****************
   // result output
   // ****************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         resValid_q <= 1'b0;
         resByte_q <= '0;
         resIdx_q <= '0;
      end else if (state_q != ST_RESULT) begin
         resValid_q <= 1'b0;
         resIdx_q <= '0;
      end else if (resValid_q) begin
         if (resReady) begin
            resValid_q <= 1'b0;
            resIdx_q <= resIdx_q + 1'b1;
         end
      end else begin
         resValid_q <= 1'b1;
         case (resIdx_q)
            3'h0: resByte_q <= st0_q;
            3'h1: resByte_q <= st1_q;
            3'h2: resByte_q <= st2_q;
            3'h3: resByte_q <= curId_q.cyl;
            3'h4: resByte_q <= curId_q.head;
            3'h5: resByte_q <= curId_q.rec;
            default: resByte_q <= curId_q.size;
         endcase
      end
   end

   // ****************
   // drive controls
   // ****************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         driveSel_q <= '0;
         headSel_q <= 1'b0;
         dblDensity_q <= 1'b0;
         readGate_q <= 1'b0;
         writeGate_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         busy_q <= (state_q != ST_IDLE);
         if (state_q == ST_PARAM && cmdValid && byteCnt_q + 1'b1 == needCnt_q) begin
            // read id ends on its select byte, so take it straight from the port
            driveSel_q <= (byteCnt_q == IDX_SEL) ? cmdByte[1:0] : cmd_q.driveSel;
            headSel_q <= (byteCnt_q == IDX_SEL) ? cmdByte[BIT_HEAD] : cmd_q.headSelect;
            dblDensity_q <= cmd_q.dblDensity;
         end
         readGate_q <= inExec && !finish && !isWrite;
         writeGate_q <= inExec && !finish && isWrite && matched_q && !drvSecEnd;
      end
   end

   assign cmdReady = (state_q == ST_IDLE) || (state_q == ST_PARAM);
   assign resValid = resValid_q;
   assign resByte = resByte_q;
   assign driveSel = driveSel_q;
   assign headSel = headSel_q;
   assign dblDensity = dblDensity_q;
   assign readGate = readGate_q;
   assign writeGate = writeGate_q;
   assign busy = busy_q;
endmodule

// File: tb/fdcx_cmd_monitor.sv
`timescale 1ns/1ns
module fdcx_cmd_monitor (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // host side
   input wire logic cmdReady,
   input wire logic resValid,
   input wire logic [7:0] resByte,
   input wire logic resReady,
   input wire logic hostWrReady,
   input wire logic hostRdValid,
   input wire logic hostRdReady,
   // drive side
   input wire logic drvRdReady,
   input wire logic drvWrValid,
   input wire logic drvWrReady,
   input wire logic [1:0] driveSel,
   input wire logic headSel,
   input wire logic dblDensity,
   input wire logic readGate,
   input wire logic writeGate,
   input wire logic busy
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ****************
   // assertions
   // ****************
   AST_RES_HOLD: assert property (resValid && !resReady |=> resValid && $stable(resByte))
      else $error("result byte changed before taken");
   AST_RES_BUBBLE: assert property (resValid && resReady |=> !resValid)
      else $error("no gap after result byte");
   AST_CMD_BLOCKED: assert property (resValid |-> !cmdReady && busy)
      else $error("command port open in result phase");
   AST_GATES_EXEC: assert property ((readGate || writeGate) |-> !cmdReady && !resValid)
      else $error("gate outside execution");
   AST_SEL_STABLE: assert property (!cmdReady && !$past(cmdReady) |->
      $stable(driveSel) && $stable(headSel) && $stable(dblDensity))
      else $error("drive controls moved during command");
   AST_DRV_WR_GATED: assert property (drvWrValid |-> writeGate && !readGate)
      else $error("drive write without write gate");
   AST_HOST_RD_ONLY: assert property (hostRdValid |-> !hostWrReady && !writeGate)
      else $error("host read during write");
   AST_IDLE_AFTER: assert property (resValid && resReady |-> ##[1:3] (cmdReady || resValid))
      else $error("result phase stalled");
   CVR_RESULT: cover property (resValid && resReady);
   CVR_HOST_RD: cover property (hostRdValid && hostRdReady);
   CVR_DRV_WR: cover property (drvWrValid && drvWrReady);
   CVR_FULL: cover property (readGate && hostRdValid && !drvRdReady);
endmodule

// File: tb/fdcx_drive_model.sv
`timescale 1ns/1ns
module fdcx_drive_model
   import fdcx_pkg::*;
(
   // controller side
   input wire logic clk_sys,
   input wire logic busy,
   input wire logic cmdReady,
   input wire logic drvRdReady,
   input wire logic drvWrValid,
   input wire logic badFirst,
   input wire logic [2:0] delRec,
   // disk side
   output logic drvIndex = 1'b0,
   output logic drvIdValid = 1'b0,
   output fdcx_pkg::fdcx_id_t drvId = '0,
   output logic drvIdCrcOk = 1'b0,
   output logic drvIdDeleted = 1'b0,
   output logic drvSecEnd = 1'b0,
   output logic drvRdValid = 1'b0,
   output logic [7:0] drvRdByte = 8'h00,
   output logic drvWrReady = 1'b0
);
   logic acc;
   // one sector: id, four data bytes, end mark
   task automatic sector(input logic [7:0] r);
      int t;
      int k;
      repeat (2) @(negedge clk_sys);
      drvIdValid = 1'b1;
      drvId = {8'h03, 8'h01, r, 8'h02};
      drvIdCrcOk = !(badFirst && r == 8'h01);
      drvIdDeleted = (r[2:0] == delRec);
      @(negedge clk_sys);
      drvIdValid = 1'b0;
      drvId = ~drvId;
      t = 0;
      k = 0;
      while (k < 4 && t < 200) begin
         drvRdValid = 1'b1;
         drvRdByte = {r[3:0], k[3:0]};
         drvWrReady = t[0] | (t > 8);
         #1;
         acc = drvRdReady || (drvWrValid && drvWrReady);
         @(negedge clk_sys);
         t++;
         if (acc) k++;
      end
      drvRdValid = 1'b0;
      drvWrReady = 1'b0;
      drvRdByte = ~drvRdByte;
      drvSecEnd = 1'b1;
      @(negedge clk_sys);
      drvSecEnd = 1'b0;
   endtask
   // revolutions run while a command executes
   initial begin
      forever begin
         @(negedge clk_sys);
         if (busy && !cmdReady) begin
            drvIndex = 1'b1;
            @(negedge clk_sys);
            drvIndex = 1'b0;
            for (int r = 1; r <= 4; r++) begin
               if (busy && !cmdReady) sector(r[7:0]);
            end
         end
      end
   end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   import fdcx_pkg::*;
   localparam logic [7:0] VER = 8'h3c; // arbitrary value
   logic clk_sys = 1'b0, rst = 1'b1, cmdValid = 1'b0, resReady = 1'b0;
   logic hostWrValid = 1'b0, hostRdReady = 1'b0, badFirst = 1'b0, rdStall = 1'b0;
   logic [7:0] cmdByte = 8'h00, hostWrByte = 8'h00;
   logic [2:0] delRec = 3'h0;
   logic [31:0] seed = 32'h00000038;
   logic cmdReady, resValid, hostWrReady, hostRdValid, drvIndex, drvIdValid, drvIdCrcOk;
   logic drvIdDeleted, drvSecEnd, drvRdValid, drvRdReady, drvWrValid, drvWrReady;
   logic headSel, dblDensity, readGate, writeGate, busy;
   logic [7:0] resByte, hostRdByte, drvRdByte, drvWrByte;
   logic [1:0] driveSel;
   fdcx_id_t drvId;
   logic [7:0] expQ[$], rdQ[$], wrQ[$];
   int err_total = 0, cmp_count = 0;
   always #5 clk_sys = ~clk_sys;
   fdcx_cmd #(.VERSION_CODE(VER), .DEPTH(FIFO_DEPTH)) fdcx_cmd_inst (
      .clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid), .cmdByte(cmdByte), .cmdReady(cmdReady),
      .resValid(resValid), .resByte(resByte), .resReady(resReady), .hostWrValid(hostWrValid),
      .hostWrByte(hostWrByte), .hostWrReady(hostWrReady), .hostRdValid(hostRdValid),
      .hostRdByte(hostRdByte), .hostRdReady(hostRdReady), .drvIndex(drvIndex),
      .drvIdValid(drvIdValid), .drvId(drvId), .drvIdCrcOk(drvIdCrcOk), .drvIdDeleted(drvIdDeleted),
      .drvSecEnd(drvSecEnd), .drvRdValid(drvRdValid), .drvRdByte(drvRdByte),
      .drvRdReady(drvRdReady), .drvWrValid(drvWrValid), .drvWrByte(drvWrByte),
      .drvWrReady(drvWrReady), .driveSel(driveSel), .headSel(headSel), .dblDensity(dblDensity),
      .readGate(readGate), .writeGate(writeGate), .busy(busy));
   fdcx_drive_model fdcx_drive_model_inst (
      .clk_sys(clk_sys), .busy(busy), .cmdReady(cmdReady), .drvRdReady(drvRdReady),
      .drvWrValid(drvWrValid), .badFirst(badFirst), .delRec(delRec), .drvIndex(drvIndex),
      .drvIdValid(drvIdValid), .drvId(drvId), .drvIdCrcOk(drvIdCrcOk),
      .drvIdDeleted(drvIdDeleted), .drvSecEnd(drvSecEnd), .drvRdValid(drvRdValid),
      .drvRdByte(drvRdByte), .drvWrReady(drvWrReady));
   // ****************
   // helpers
   // ****************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [7:0] pop(ref logic [7:0] q[$]);
      if (q.size() == 0) return 8'hxx;
      return q.pop_front();
   endfunction
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic put(input logic [7:0] b);
      int t;
      t = 0;
      @(negedge clk_sys);
      cmdValid = 1'b1;
      cmdByte = b;
      while (!cmdReady && t < 5000) begin
         @(negedge clk_sys);
         t++;
      end
      @(negedge clk_sys);
      cmdValid = 1'b0;
   endtask
   task automatic run(input logic [7:0] c[$], input logic [7:0] e[$]);
      int t;
      foreach (e[i]) expQ.push_back(e[i]);
      foreach (c[i]) put(c[i]);
      if (c.size() > 1) chk("drive controls", {4'h0, c[0][6], c[1][2], c[1][1:0]},
         {4'h0, dblDensity, headSel, driveSel});
      t = 0;
      while ((expQ.size() > 0 || !cmdReady) && t < 20000) begin
         @(negedge clk_sys);
         t++;
      end
      chk("command done", 8'h01, {7'h00, t < 20000});
   endtask
   task automatic push_host(input int n);
      int t;
      for (int i = 0; i < n; i++) begin
         @(negedge clk_sys);
         seed = xs(seed);
         hostWrValid = 1'b1;
         hostWrByte = seed[7:0];
         wrQ.push_back(seed[7:0]);
         t = 0;
         #1;
         while (!hostWrReady && t < 5000) begin
            @(negedge clk_sys);
            t++;
         end
      end
      @(negedge clk_sys);
      hostWrValid = 1'b0;
   endtask
   // ****************
   // watchers
   // ****************
   always @(negedge clk_sys) begin
      seed = xs(seed);
      resReady <= seed[0];
      hostRdReady <= seed[1] && !rdStall;
   end
   always @(posedge clk_sys) begin
      if (resValid === 1'b1 && resReady) chk("result", pop(expQ), resByte);
      if (hostRdValid === 1'b1 && hostRdReady) chk("host read", pop(rdQ), hostRdByte);
      if (drvWrValid === 1'b1 && drvWrReady) chk("drive write", pop(wrQ), drvWrByte);
   end
   initial begin
      #400000;
      err_total++;
      $display("[ERR] run expected end seen timeout");
      finish_test();
   end
   // ****************
   // scenarios
   // ****************
   initial begin
      repeat (16) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      run('{8'h10}, '{VER});
      run('{8'h1f}, '{ST0_INVALID});
      badFirst = 1'b1;
      run('{8'h4a, 8'h05}, '{8'h05, 8'h00, 8'h00, 8'h03, 8'h01, 8'h02, 8'h02});
      badFirst = 1'b0;
      delRec = 3'h2;
      run('{8'h36, 8'h05, 8'h03, 8'h01, 8'h01, 8'h02, 8'h03, 8'h1b, 8'hff},
         '{8'h05, 8'h00, 8'h40, 8'h03, 8'h01, 8'h03, 8'h02});
      delRec = 3'h0;
      run('{8'h56, 8'h85, 8'h03, 8'h01, 8'h01, 8'h02, 8'h09, 8'h1b, 8'h02},
         '{8'h05, 8'h00, 8'h00, 8'h03, 8'h01, 8'h02, 8'h02});
      run('{8'h16, 8'h05, 8'h03, 8'h01, 8'h07, 8'h02, 8'h04, 8'h1b, 8'hff},
         '{8'h45, 8'h01, 8'h00, 8'h03, 8'h01, 8'h07, 8'h02});
      fork
         run('{8'h45, 8'h05, 8'h03, 8'h01, 8'h02, 8'h02, 8'h02, 8'h1b, 8'hff},
            '{8'h05, 8'h00, 8'h00, 8'h03, 8'h01, 8'h02, 8'h02});
         push_host(4);
      join
      for (int r = 1; r <= 3; r++) begin
         for (int k = 0; k < 4; k++) rdQ.push_back({r[3:0], k[3:0]});
      end
      rdStall = 1'b1;
      fork
         run('{8'h42, 8'h05, 8'h03, 8'h01, 8'h01, 8'h02, 8'h03, 8'h1b, 8'hff},
            '{8'h05, 8'h00, 8'h00, 8'h03, 8'h01, 8'h03, 8'h02});
         begin
            // hold the host off until the full buffer pushes back on the drive
            do begin
               @(negedge clk_sys);
               #1;
            end while (!(readGate && hostRdValid && drvRdValid && !drvRdReady));
            rdStall = 1'b0;
         end
      join
      chk("reads left", 8'h00, 8'(rdQ.size()));
      chk("writes left", 8'h00, 8'(wrQ.size()));
      finish_test();
   end
endmodule
bind fdcx_cmd fdcx_cmd_monitor fdcx_cmd_monitor_inst (
   .clk_sys(clk_sys), .rst(rst), .cmdReady(cmdReady), .resValid(resValid), .resByte(resByte),
   .resReady(resReady), .hostWrReady(hostWrReady), .hostRdValid(hostRdValid),
   .hostRdReady(hostRdReady), .drvRdReady(drvRdReady), .drvWrValid(drvWrValid),
   .drvWrReady(drvWrReady), .driveSel(driveSel), .headSel(headSel), .dblDensity(dblDensity),
   .readGate(readGate), .writeGate(writeGate), .busy(busy));
